/* rsd_consts.svh */
`ifndef RSD_CONSTS_SVH
`define RSD_CONSTS_SVH

`define RSD_MSB        7
`define RSD_LSB        0
`define RSD_NIB_MSB    3
`define RSD_FLAG_RESET 1'h0
`define RSD_ZERO_BYTE  8'h00
`define RSD_ONE_BYTE   8'h01

`endif

/* rsd_pkg.sv */
package rsd_pkg;

	typedef enum logic [3:0] {
		rotate_left_thru_carry_mem         = 4'h0,
		rotate_left_thru_carry_to_working  = 4'h1,
		rotate_right_mem                   = 4'h2,
		rotate_right_to_working            = 4'h3,
		rotate_right_thru_carry_mem        = 4'h4,
		rotate_right_thru_carry_to_working = 4'h5,
		subtract_with_borrow               = 4'h6,
		subtract_with_borrow_to_mem        = 4'h7,
		decrement_skip_if_zero             = 4'h8,
		decrement_skip_to_working          = 4'h9
	} rsd_op_t;

	typedef enum logic [0:0] {
		RSD_ST_EXEC  = 1'b0,
		RSD_ST_DUMMY = 1'b1
	} rsd_state_t;

endpackage

/* rsd_alu_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rsd_alu_if;
	rsd_pkg::rsd_op_t op;
	logic [7:0]       mem_byte;
	logic [7:0]       acc_byte;
	logic             carry;
	logic [7:0]       result;
	logic             carry_next;
	logic             ac_next;
	logic             ov_next;
	logic             zero;
	logic             write_mem;
	logic             write_acc;
	logic             upd_carry;
	logic             upd_arith;
	logic             skip;

	modport core (output op, mem_byte, acc_byte, carry,
		input result, carry_next, ac_next, ov_next, zero,
		write_mem, write_acc, upd_carry, upd_arith, skip);
	modport alu (input op, mem_byte, acc_byte, carry,
		output result, carry_next, ac_next, ov_next, zero,
		write_mem, write_acc, upd_carry, upd_arith, skip);
endinterface

`default_nettype wire

/* rsd_alu.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rsd_consts.svh"

module rsd_alu (
	rsd_alu_if.alu a
);
	wire [7:0] m = a.mem_byte;
	wire [7:0] mem_inv = ~a.mem_byte;
	wire [8:0] sbc_sum = {1'b0, a.acc_byte} + {1'b0, mem_inv} + {8'h00, a.carry};
	wire [4:0] sbc_nib = {1'b0, a.acc_byte[`RSD_NIB_MSB:0]}
		+ {1'b0, mem_inv[`RSD_NIB_MSB:0]} + {4'h0, a.carry};
	wire [7:0] dec_val = m - `RSD_ONE_BYTE;

	wire is_rlc = (a.op == rsd_pkg::rotate_left_thru_carry_mem)
		|| (a.op == rsd_pkg::rotate_left_thru_carry_to_working);
	wire is_rr  = (a.op == rsd_pkg::rotate_right_mem)
		|| (a.op == rsd_pkg::rotate_right_to_working);
	wire is_rrc = (a.op == rsd_pkg::rotate_right_thru_carry_mem)
		|| (a.op == rsd_pkg::rotate_right_thru_carry_to_working);
	wire is_sbc = (a.op == rsd_pkg::subtract_with_borrow)
		|| (a.op == rsd_pkg::subtract_with_borrow_to_mem);
	wire is_dec = (a.op == rsd_pkg::decrement_skip_if_zero)
		|| (a.op == rsd_pkg::decrement_skip_to_working);

	// bit moves per rotate family
	wire [7:0] rlc_val = {m[`RSD_MSB-1:`RSD_LSB], a.carry};
	wire [7:0] rr_val  = {m[`RSD_LSB], m[`RSD_MSB:`RSD_LSB+1]};
	wire [7:0] rrc_val = {a.carry, m[`RSD_MSB:`RSD_LSB+1]};

	assign a.result = is_rlc ? rlc_val :
		is_rr  ? rr_val :
		is_rrc ? rrc_val :
		is_sbc ? sbc_sum[7:0] :
		dec_val;
	assign a.carry_next = is_rlc ? m[`RSD_MSB] :
		is_rrc ? m[`RSD_LSB] :
		is_sbc ? sbc_sum[8] :
		a.carry;
	assign a.ac_next   = sbc_nib[4];
	// overflow: operands of like sign giving a result of the other sign
	assign a.ov_next   = (a.acc_byte[`RSD_MSB] == mem_inv[`RSD_MSB])
		&& (sbc_sum[`RSD_MSB] != a.acc_byte[`RSD_MSB]);
	assign a.zero      = (a.result == `RSD_ZERO_BYTE);
	// working variants leave memory alone
	assign a.write_acc = (a.op == rsd_pkg::rotate_left_thru_carry_to_working)
		|| (a.op == rsd_pkg::rotate_right_to_working)
		|| (a.op == rsd_pkg::rotate_right_thru_carry_to_working)
		|| (a.op == rsd_pkg::subtract_with_borrow)
		|| (a.op == rsd_pkg::decrement_skip_to_working);
	assign a.write_mem = (is_rlc || is_rr || is_rrc || is_sbc || is_dec) && !a.write_acc;
	assign a.upd_carry = is_rlc || is_rrc || is_sbc;
	assign a.upd_arith = is_sbc;
	assign a.skip      = is_dec && (dec_val == `RSD_ZERO_BYTE);
endmodule

`default_nettype wire

/* rsd_datapath.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rsd_consts.svh"

module rsd_datapath (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             op_valid,
	input  wire rsd_pkg::rsd_op_t op_code,
	input  wire logic [7:0]       mem_rd_data,
	input  wire logic [7:0]       acc_rd_data,
	output logic                  op_ready,
	output logic                  mem_wr_en,
	output logic                  acc_wr_en,
	output logic [7:0]            wr_data,
	output logic                  carry_flag,
	output logic                  zero_flag,
	output logic                  aux_carry_flag,
	output logic                  overflow_flag,
	output logic                  skip_next
);
	rsd_alu_if alu_bus ();

	rsd_pkg::rsd_state_t state_reg;
	rsd_pkg::rsd_state_t state_next;
	logic       mem_wr_reg;
	logic       acc_wr_reg;
	logic [7:0] data_reg;
	logic       c_reg;
	logic       z_reg;
	logic       ac_reg;
	logic       ov_reg;
	logic       skip_reg;

	rsd_alu u_alu (
		.a (alu_bus)
	);

	wire take = op_valid && op_ready;

	assign alu_bus.op       = op_code;
	assign alu_bus.mem_byte = mem_rd_data;
	assign alu_bus.acc_byte = acc_rd_data;
	assign alu_bus.carry    = c_reg;

	// no new operation during the dummy cycle of a taken skip
	assign op_ready   = (state_reg == rsd_pkg::RSD_ST_EXEC);
	// dummy cycle lasts one clock, never chains
	always_comb begin
		case (state_reg)
			rsd_pkg::RSD_ST_EXEC: begin
				if (take && alu_bus.skip) begin
					state_next = rsd_pkg::RSD_ST_DUMMY;
				end else begin
					state_next = rsd_pkg::RSD_ST_EXEC;
				end
			end
			rsd_pkg::RSD_ST_DUMMY: begin
				state_next = rsd_pkg::RSD_ST_EXEC;
			end
			default: begin
				state_next = rsd_pkg::RSD_ST_EXEC;
			end
		endcase
	end

	assign mem_wr_en      = mem_wr_reg;
	assign acc_wr_en      = acc_wr_reg;
	assign wr_data        = data_reg;
	assign carry_flag     = c_reg;
	assign zero_flag      = z_reg;
	assign aux_carry_flag = ac_reg;
	assign overflow_flag  = ov_reg;
	assign skip_next      = skip_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= rsd_pkg::RSD_ST_EXEC;
			mem_wr_reg <= 1'b0;
			acc_wr_reg <= 1'b0;
			data_reg   <= `RSD_ZERO_BYTE;
			skip_reg   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			mem_wr_reg <= take && alu_bus.write_mem;
			acc_wr_reg <= take && alu_bus.write_acc;
			skip_reg   <= take && alu_bus.skip;
			if (take) begin
				data_reg <= alu_bus.result;
			end
		end
	end

	// flags only move for the operations that own them
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			c_reg  <= `RSD_FLAG_RESET;
			z_reg  <= `RSD_FLAG_RESET;
			ac_reg <= `RSD_FLAG_RESET;
			ov_reg <= `RSD_FLAG_RESET;
		end else begin
			if (take && alu_bus.upd_carry) begin
				c_reg <= alu_bus.carry_next;
			end
			if (take && alu_bus.upd_arith) begin
				z_reg  <= alu_bus.zero;
				ac_reg <= alu_bus.ac_next;
				ov_reg <= alu_bus.ov_next;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	wire [8:0] chk_sbc = {1'b0, acc_rd_data} + {1'b0, ~mem_rd_data} + {8'h00, c_reg};
	wire [4:0] chk_nib = {1'b0, acc_rd_data[3:0]} + {1'b0, ~mem_rd_data[3:0]} + {4'h0, c_reg};
	// sign-extended sum: bits 8 and 7 disagree only on signed overflow
	wire [8:0] chk_ssum = {acc_rd_data[7], acc_rd_data} + {~mem_rd_data[7], ~mem_rd_data}
		+ {8'h00, c_reg};

	rlc_mem_a: assert property (
		take && op_code == rsd_pkg::rotate_left_thru_carry_mem
		|=> mem_wr_en && !acc_wr_en
			&& wr_data == {$past(mem_rd_data[6:0]), $past(c_reg)}
			&& carry_flag == $past(mem_rd_data[7]))
		else $error("rotate left through carry to memory wrong");

	rlc_work_a: assert property (
		take && op_code == rsd_pkg::rotate_left_thru_carry_to_working
		|=> acc_wr_en && !mem_wr_en && carry_flag == $past(mem_rd_data[7])
			&& wr_data[0] == $past(c_reg))
		else $error("working rotate left through carry wrong");

	rr_mem_a: assert property (
		take && op_code == rsd_pkg::rotate_right_mem
		|=> mem_wr_en && $stable(carry_flag)
			&& wr_data == {$past(mem_rd_data[0]), $past(mem_rd_data[7:1])})
		else $error("plain right rotate to memory wrong");

	rr_work_a: assert property (
		take && op_code == rsd_pkg::rotate_right_to_working
		|=> acc_wr_en && !mem_wr_en && wr_data[7] == $past(mem_rd_data[0]))
		else $error("working plain right rotate wrong");

	rrc_ring_a: assert property (
		take && (op_code == rsd_pkg::rotate_right_thru_carry_mem
			|| op_code == rsd_pkg::rotate_right_thru_carry_to_working)
		|=> {wr_data, carry_flag} == {$past(c_reg), $past(mem_rd_data)})
		else $error("nine bit right ring wrong");

	sbc_sum_a: assert property (
		take && op_code == rsd_pkg::subtract_with_borrow
		|=> acc_wr_en && {carry_flag, wr_data} == $past(chk_sbc)
			&& zero_flag == (wr_data == 8'h00))
		else $error("subtract with borrow result wrong");

	subtract_with_borrow_to_mem_dest_a: assert property (
		take && op_code == rsd_pkg::subtract_with_borrow_to_mem |=> mem_wr_en && !acc_wr_en)
		else $error("memory subtract destination wrong");

	dz_skip_a: assert property (
		take && op_code == rsd_pkg::decrement_skip_if_zero && mem_rd_data == 8'h01
		|=> skip_next && mem_wr_en && wr_data == 8'h00 && !op_ready ##1 op_ready && !skip_next)
		else $error("decrement skip timing wrong");

	dz_noskip_a: assert property (
		take && op_code == rsd_pkg::decrement_skip_to_working && mem_rd_data != 8'h01
		|=> !skip_next && op_ready && acc_wr_en && !mem_wr_en)
		else $error("decrement without zero must not skip");

	rlc_work_val_a: assert property (
		take && op_code == rsd_pkg::rotate_left_thru_carry_to_working
		|=> wr_data == {$past(mem_rd_data[6:0]), $past(c_reg)})
		else $error("working rotate left through carry value wrong");

	rr_work_val_a: assert property (
		take && op_code == rsd_pkg::rotate_right_to_working
		|=> $stable(carry_flag)
			&& wr_data == {$past(mem_rd_data[0]), $past(mem_rd_data[7:1])})
		else $error("working plain right rotate value wrong");

	rrc_dest_a: assert property (
		take && op_code == rsd_pkg::rotate_right_thru_carry_to_working
		|=> acc_wr_en && !mem_wr_en)
		else $error("working right ring destination wrong");

	rrc_mem_dest_a: assert property (
		take && op_code == rsd_pkg::rotate_right_thru_carry_mem |=> mem_wr_en && !acc_wr_en)
		else $error("memory right ring destination wrong");

	sbc_flags_a: assert property (
		take && (op_code == rsd_pkg::subtract_with_borrow
			|| op_code == rsd_pkg::subtract_with_borrow_to_mem)
		|=> aux_carry_flag == $past(chk_nib[4])
			&& overflow_flag == ($past(chk_ssum[8]) != $past(chk_ssum[7])))
		else $error("subtract with borrow flags wrong");

	subtract_with_borrow_to_mem_sum_a: assert property (
		take && op_code == rsd_pkg::subtract_with_borrow_to_mem
		|=> {carry_flag, wr_data} == $past(chk_sbc) && zero_flag == (wr_data == 8'h00))
		else $error("memory subtract result wrong");

	arith_flags_hold_a: assert property (
		take && op_code != rsd_pkg::subtract_with_borrow
			&& op_code != rsd_pkg::subtract_with_borrow_to_mem
		|=> $stable({zero_flag, aux_carry_flag, overflow_flag}))
		else $error("flags moved outside subtract with borrow");

	dz_mem_a: assert property (
		take && op_code == rsd_pkg::decrement_skip_if_zero && mem_rd_data != 8'h01
		|=> mem_wr_en && !acc_wr_en && !skip_next && op_ready
			&& wr_data == $past(mem_rd_data) - 8'h01)
		else $error("memory decrement without skip wrong");

	no_take_quiet_a: assert property (
		!take |=> !mem_wr_en && !acc_wr_en && !skip_next
			&& $stable(wr_data) && $stable(carry_flag))
		else $error("write or skip without a taken operation");

	rlc_cov: cover property (take && op_code == rsd_pkg::rotate_left_thru_carry_mem);
	rrc_cov: cover property (take && op_code == rsd_pkg::rotate_right_thru_carry_to_working);
	sbc_cov: cover property (take && op_code == rsd_pkg::subtract_with_borrow ##1 overflow_flag);
	skip_cov: cover property (skip_next ##1 !op_ready);
endmodule

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic             clk;
	logic             nrst;
	logic             op_valid;
	rsd_pkg::rsd_op_t op_code;
	logic [7:0]       mem_rd_data;
	logic [7:0]       acc_rd_data;
	logic [7:0]       wr_data;
	logic             op_ready;
	logic             mem_wr_en;
	logic             acc_wr_en;
	logic             carry_flag;
	logic             zero_flag;
	logic             aux_carry_flag;
	logic             overflow_flag;
	logic             skip_next;
	integer           err_total;
	integer           tests_run;
	integer           seed;
	integer           i;
	logic             c_m, z_m, ac_m, ov_m, wm_m, wa_m, sk_m;
	logic [7:0]       r_m;

	rsd_datapath i_rsd_datapath (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
		.mem_rd_data(mem_rd_data), .acc_rd_data(acc_rd_data), .op_ready(op_ready),
		.mem_wr_en(mem_wr_en), .acc_wr_en(acc_wr_en), .wr_data(wr_data),
		.carry_flag(carry_flag), .zero_flag(zero_flag), .aux_carry_flag(aux_carry_flag),
		.overflow_flag(overflow_flag), .skip_next(skip_next));

	always #5 clk = ~clk;

	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// reference model; flags persist between calls like the block's own
	function automatic void predict(input logic [3:0] op, input logic [7:0] m, input logic [7:0] a);
		logic [8:0] s;
		logic [4:0] h;
		wm_m = 1'b0;
		wa_m = 1'b0;
		sk_m = 1'b0;
		case (op)
			4'h0, 4'h1: begin
				r_m = {m[6:0], c_m};
				c_m = m[7];
			end
			4'h2, 4'h3: r_m = {m[0], m[7:1]};
			4'h4, 4'h5: begin
				r_m = {c_m, m[7:1]};
				c_m = m[0];
			end
			4'h6, 4'h7: begin
				s = {1'b0, a} + {1'b0, ~m} + {8'h00, c_m};
				h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c_m};
				r_m = s[7:0];
				c_m = s[8];
				ac_m = h[4];
				z_m = (s[7:0] == 8'h00);
				ov_m = (a[7] ^ m[7]) & (s[7] ^ a[7]);
			end
			4'h8, 4'h9: begin
				r_m = m - 8'h01;
				sk_m = (r_m == 8'h00);
			end
			default: ;
		endcase
		// even codes of the table go to memory, odd ones to the working register, except 4'h6 to the working register and 4'h7 to memory
		if (op <= 4'h9) begin
			wm_m = ~op[0] ^ (op == 4'h6 || op == 4'h7);
			wa_m = ~wm_m;
		end
	endfunction

	task do_op(input logic [3:0] op, input logic [7:0] m, input logic [7:0] a);
		integer k;
		// refused requests during the dummy cycle must write nothing
		for (k = 0; k < 3 && op_ready !== 1'b1; k++) begin
			@(posedge clk);
			#1;
			chk("refused_writes", 8'h00, {5'h00, mem_wr_en, acc_wr_en, skip_next});
		end
		if (op_ready !== 1'b1) begin
			chk("ready_wait", 8'h01, 8'h00);
			report_and_stop;
		end else begin
			op_valid = 1'b1;
			op_code = rsd_pkg::rsd_op_t'(op);
			mem_rd_data = m;
			acc_rd_data = a;
			predict(op, m, a);
			@(posedge clk);
			#1;
			chk("mem_wr_en", {7'h00, wm_m}, {7'h00, mem_wr_en});
			chk("acc_wr_en", {7'h00, wa_m}, {7'h00, acc_wr_en});
			if (op <= 4'h9)
				chk("wr_data", r_m, wr_data);
			chk("carry", {7'h00, c_m}, {7'h00, carry_flag});
			chk("flags", {5'h00, z_m, ac_m, ov_m},
				{5'h00, zero_flag, aux_carry_flag, overflow_flag});
			chk("skip", {6'h00, sk_m, ~sk_m}, {6'h00, skip_next, op_ready});
		end
	endtask

	// no request for one cycle: nothing may be written or skipped
	task idle_cycle;
		op_valid = 1'b0;
		@(posedge clk);
		#1;
		chk("idle_writes", 8'h00, {5'h00, mem_wr_en, acc_wr_en, skip_next});
	endtask

	task do_reset;
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		nrst = 1'b1;
		{c_m, z_m, ac_m, ov_m, r_m} = 12'h000;
		chk("reset_out", 8'h01, {carry_flag, zero_flag, aux_carry_flag, overflow_flag,
			skip_next, mem_wr_en, acc_wr_en, op_ready});
	endtask

	initial begin
		clk = 1'b0;
		op_valid = 1'b0;
		op_code = rsd_pkg::rsd_op_t'(4'h0);
		mem_rd_data = 8'h00;
		acc_rd_data = 8'h00;
		err_total = 0;
		tests_run = 0;
		seed = 78458;
		do_reset;
		// corner cases: carry in and out, ring wrap, skip back to back, borrow overflow
		do_op(4'h0, 8'h81, 8'h00);
		do_op(4'h1, 8'h40, 8'h00);
		do_op(4'h2, 8'h01, 8'h00);
		do_op(4'h3, 8'hFE, 8'h00);
		do_op(4'h4, 8'h01, 8'h00);
		do_op(4'h5, 8'h00, 8'h00);
		do_op(4'h6, 8'h03, 8'h05);
		do_op(4'h7, 8'h01, 8'h80);
		do_op(4'h8, 8'h01, 8'h00);
		do_op(4'h9, 8'h01, 8'h00);
		do_op(4'h8, 8'h00, 8'h00);
		do_op(4'hF, 8'h55, 8'hAA);
		$display("test corner done");
		for (i = 0; i < 400; i++) begin
			if ($unsigned($random(seed)) % 8 == 0)
				idle_cycle;
			do_op(4'($unsigned($random(seed)) % 10), 8'($random(seed)), 8'($random(seed)));
		end
		$display("test random done");
		op_valid = 1'b0;
		do_reset;
		do_op(4'h4, 8'h01, 8'h00);
		$display("test second reset done");
		report_and_stop;
	end
endmodule

`default_nettype wire
